// [tb/spcc_host_model.sv]
// serial bus host model driving the clock generator's two-wire port
module spcc_host_model (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // bus timing
  // 250 core cycles a bit, 10 us, so never above 100 kbit/s
  localparam int HP = 124;
  localparam int Q = 63;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // ==========================================================
  // bus conditions and bytes
  // also serves as repeated start
  task automatic bus_start();
    sda_drv <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_drv <= 1'b0;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask

  task automatic bus_stop();
    sda_drv <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_drv <= 1'b1;
    tick(Q);
  endtask

  // sample mid-high, far from the device's drive change
  task automatic pulse(output logic s);
    tick(Q);
    scl <= 1'b1;
    tick(HP / 2);
    s = sda_line;
    tick(HP / 2);
    scl <= 1'b0;
    tick(Q);
  endtask

  task automatic put_bits(input logic [7:0] b, input int n);
    logic s;
    for (int i = 7; i > 7 - n; i--) begin
      sda_drv <= b[i];
      pulse(s);
    end
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    put_bits(b, 8);
    sda_drv <= 1'b1;
    pulse(s);
    ack = !s;
  endtask

  task automatic get_byte(output logic [7:0] b, input logic ack_it);
    logic s;
    sda_drv <= 1'b1;
    for (int i = 7; i >= 0; i--) pulse(b[i]);
    sda_drv <= !ack_it;
    pulse(s);
  endtask
endmodule

// [tb/spcc_monitor.sv]
// checker of serial drive timing and clock output rules
module spcc_monitor
  import spcc_pkg::*;
#(
  parameter int NUM_OUTPUTS = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [3:0] freq_select_pins,
  input wire logic clk_stop_n,
  input wire logic synth_clk,
  input wire logic [NUM_OUTPUTS-1:0] out_run,
  input wire logic out_hiz,
  input wire logic spread_en,
  input wire logic spread_deep,
  input wire logic [3:0] freq_code,
  input wire logic [15:0] freq_10khz
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_q;
  logic [7:0] since_fall;

  // ==========================================================
  // cycles since the serial clock pin fell, saturating
  always_ff @(posedge core_clk) begin
    scl_q <= scl;
    if (rst) since_fall <= 8'hFF;
    else if (scl_q && !scl) since_fall <= 8'h01;
    else if (since_fall != 8'hFF) since_fall <= since_fall + 8'h01;
  end

  // ==========================================================
  // serial side
  a_oe_after_fall:
  assert property (@(posedge core_clk) disable iff (rst)
    $changed(sda_oe) |-> since_fall inside {[8'h02:8'h09]}) else $error("sda drive moved off a clock fall");
  a_open_drain:
  assert property (@(posedge core_clk) disable iff (rst) sda_oe |-> !sda_o) else $error("sda driven high");
  a_oe_after_reset:
  assert property (@(posedge core_clk) disable iff (rst) $fell(rst) |-> !sda_oe [*8]) else $error("sda driven at reset");

  // ==========================================================
  // output side
  a_outs_reset:
  assert property (@(posedge synth_clk) disable iff (rst) $fell(rst) |->
    out_run == '1 && !out_hiz && !spread_en && !spread_deep) else $error("outputs not at defaults");
  a_stop_all:
  assert property (@(posedge synth_clk) disable iff (rst)
    !clk_stop_n [*6] |-> out_run == '0) else $error("outputs run while stopped");
  // code 1000 differs by source, so it is left to the bench
  a_freq_table:
  assert property (@(posedge synth_clk) disable iff (rst) $stable(freq_code) && freq_code != 4'h8 |->
    freq_10khz == SPCC_FREQ_TABLE[freq_code]) else $error("frequency off the table");
  a_spread_in_frame:
  assert property (@(posedge synth_clk) disable iff (rst) $changed(spread_en) |-> scl) else $error("spread moved");
  a_depth_in_frame:
  assert property (@(posedge synth_clk) disable iff (rst) $changed(spread_deep) |-> scl) else $error("depth moved");
  a_hiz_in_frame:
  assert property (@(posedge synth_clk) disable iff (rst) $changed(out_hiz) |-> scl) else $error("hiz moved");

  c_ack: cover property (@(posedge core_clk) disable iff (rst) $rose(sda_oe));
  c_stopped: cover property (@(posedge synth_clk) disable iff (rst) out_run == '0);
  c_reg_code: cover property (@(posedge synth_clk) disable iff (rst) freq_code == 4'hF);
endmodule

bind spcc_top spcc_monitor #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_monitor (.core_clk, .rst, .scl, .sda_i, .sda_o,
  .sda_oe, .freq_select_pins, .clk_stop_n, .synth_clk, .out_run, .out_hiz, .spread_en, .spread_deep,
  .freq_code, .freq_10khz);

// [tb/tb_top.sv]
// self-checking bench of the serial programmed clock control
module tb_top;
  import spcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] pins;
    logic [3:0] code;
    logic [15:0] f;
    logic [2:0] fl;
  } spcc_row_type;
  logic core_clk = 1'b0;
  logic synth_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_stop_n = 1'b1;
  logic [3:0] pins = 4'h0;
  logic scl, sda_drv, sda_line, sda_o, sda_oe, out_hiz, spread_en, spread_deep;
  logic [7:0] out_run;
  logic [3:0] freq_code;
  logic [15:0] freq_10khz;
  int n_mismatch = 0;
  int n_checks = 0;
  // {hiz, spread, deep} in fl
  spcc_row_type rows[4] = '{
    '{8'h00, 4'h8, 4'h8, 16'h2328, 3'h0},
    '{8'h0C, 4'h0, 4'h8, 16'h238C, 3'h0},
    '{8'h7E, 4'h0, 4'hF, 16'h0D05, 3'h2},
    '{8'h81, 4'hD, 4'hD, 16'h1770, 3'h5}};

  always #20 core_clk = ~core_clk;
  always #24 synth_clk = ~synth_clk;
  // pulled-up open-drain line
  assign sda_line = (sda_oe ? sda_o : 1'b1) & sda_drv;

  spcc_top #(.NUM_OUTPUTS(8)) DUT (.core_clk, .rst, .scl, .sda_i(sda_line), .sda_o, .sda_oe,
    .freq_select_pins(pins), .clk_stop_n, .synth_clk, .out_run, .out_hiz, .spread_en, .spread_deep,
    .freq_code, .freq_10khz);
  spcc_host_model host (.core_clk, .sda_line, .scl, .sda_drv);

  // ==========================================================
  // checking and bus tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] b[$], input int n_ack);
    logic ack;
    host.bus_start();
    foreach (b[i]) begin
      host.put_byte(b[i], ack);
      chk(ack, i < n_ack);
    end
    host.bus_stop();
    repeat (30) @(posedge core_clk);
  endtask

  task automatic outs(input logic [7:0] run, input logic [2:0] fl);
    chk(out_run, run);
    chk({out_hiz, spread_en, spread_deep}, fl);
  endtask

  // ==========================================================
  // scenarios
  initial begin
    logic [7:0] rb[7];
    logic ack;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (20) @(posedge core_clk);
    outs(8'hFF, 3'h0);
    chk(freq_10khz, 16'h3416);
    foreach (rows[i]) begin
      pins <= rows[i].pins;
      wr({8'hD2, 8'h00, 8'h00, rows[i].cfg}, 4);
      chk(freq_code, rows[i].code);
      chk(freq_10khz, rows[i].f);
      chk({out_hiz, spread_en, spread_deep}, rows[i].fl);
    end
    // full block plus one byte too many
    pins <= 4'h0;
    wr({8'hD2, 8'hA5, 8'h3C, 8'h00, 8'h5A, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, 9);
    outs(8'h5A, 3'h0);
    host.bus_start();
    host.put_byte(8'hD3, ack);
    chk(ack, 1'b1);
    for (int i = 0; i < 7; i++) host.get_byte(rb[i], 1'b1);
    host.bus_stop();
    chk(rb[0], 8'h06);
    chk(rb[1], 8'h00);
    chk(rb[2], 8'h5A);
    for (int i = 3; i < 7; i++) chk(rb[i], 8'h00);
    clk_stop_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(out_run, 8'h00);
    clk_stop_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk(out_run, 8'h5A);
    // byte 1 cut short by a stop
    host.bus_start();
    foreach (rows[i]) host.put_byte(i == 3 ? 8'h02 : (i == 0 ? 8'hD2 : 8'h00), ack);
    host.put_bits(8'h00, 3);
    host.bus_stop();
    repeat (30) @(posedge core_clk);
    outs(8'h5A, 3'h2);
    // no data byte after the count: nothing changes
    wr({8'hD2, 8'h01, 8'h00}, 3);
    wr({8'hD0}, 0);
    outs(8'h5A, 3'h2);
    chk(sda_oe, 1'b0);
    rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (20) @(posedge core_clk);
    outs(8'hFF, 3'h0);
    report_and_stop();
  end

  // 381 bits at 250 cycles plus frames: run needs about 99600 cycles
  initial begin
    repeat (106000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule

// [verilog/spcc_pkg.sv]
// constants, types and field layout of the serial programmed clock control
// Operation
// [R1] write begins with start then address D2 hex; device acknowledges it.
// [R2] host sends command byte and count byte; device ignores both contents.
// [R3] only block writes accepted; no single-byte or register-addressed writes.
// [R4] device acknowledges command, count and every data byte, one at a time.
// [R5] data bytes go in ascending order 0 to 5; host may stop after any.
// [R6] received data bytes keep loading into latches until the stop.
// [R7] a byte cut short by stop or start is dropped; earlier bytes stay.
// [R8] read begins with start then address D3 hex; device acknowledges it.
// [R9] after read address ack, device sends byte count, then bytes 0 to 5.
// [R10] host acknowledges count and every data byte, then ends with stop.
// [R11] read data is the current content of the configuration latches.
// [R12] serial bit rate up to 100 kbit/s; host never clocks faster.
// [R13] every serial unit is eight bits, shifted whole before each acknowledge.
// [R14] at reset every configuration register takes its default, no access needed.
// [R15] source bit 3 clear: pins pick frequency; set: register bits 2, 6:4 pick.
// [R16] pin code is four bits; 0000 is 133.34 MHz, 1000 is 90.00 MHz.
// [R17] register code bit 2 msb, 6:4; 1000 is 91.00, 1111 is 33.33 MHz.
// [R18] bit 1 set enables spread modulation; clear gives normal operation.
// [R19] bit 7 picks spread depth: 0 gives -0.5 percent, 1 gives -1.0.
// [R20] bit 0 clear keeps outputs running; set puts them in high impedance.
// [R21] first register resets to zero, so pins control frequency after power-on.
// [R22] second register bit n gates output n; 1 runs, 0 stops low; default ones.
// [R23] active-low stop-all input halts every output regardless of gating bits.
package spcc_pkg;

  // ==========================================================
  // serial addresses and transfer layout
  localparam logic [7:0] SPCC_WR_ADDR = 8'hD2;
  localparam logic [7:0] SPCC_RD_ADDR = 8'hD3;
  localparam logic [7:0] SPCC_BYTE_COUNT = 8'h06;
  localparam logic [3:0] SPCC_POS_WR_DATA = 4'h3;
  localparam logic [3:0] SPCC_POS_RD_DATA = 4'h2;
  localparam logic [3:0] SPCC_LAST_DATA = 4'h5;
  localparam logic [2:0] SPCC_LAST_BIT = 3'h7;

  // ==========================================================
  // register offsets, reset values, fields
  localparam logic [3:0] SPCC_REG_CFG = 4'h0;
  localparam logic [3:0] SPCC_REG_GATE = 4'h1;
  localparam logic [7:0] SPCC_CFG_RESET = 8'h00;
  localparam logic [7:0] SPCC_GATE_RESET = 8'hFF;
  localparam int SPCC_BIT_HIZ = 0;
  localparam int SPCC_BIT_SPREAD = 1;
  localparam int SPCC_BIT_FMSB = 2;
  localparam int SPCC_BIT_FSRC = 3;
  localparam int SPCC_BIT_FLO = 4;
  localparam int SPCC_BIT_DEPTH = 7;

  // ==========================================================
  // timing
  localparam int SPCC_CORE_CLK_NS = 40;
  localparam int SPCC_SCL_MAX_KHZ = 100;
  localparam int SPCC_SCL_MIN_HIGH_NS = 4000;
  localparam int SPCC_SCL_HIGH_CYCLES = (SPCC_SCL_MIN_HIGH_NS + SPCC_CORE_CLK_NS - 1) / SPCC_CORE_CLK_NS;
  localparam int SPCC_MIN_SAMPLE_CYCLES = 6;

  // ==========================================================
  // frequency table in 10 kHz units
  localparam logic [15:0] SPCC_FREQ_TABLE [16] = '{
    16'h3416, 16'h30D5, 16'h2EE0, 16'h2CEB, 16'h2AF7, 16'h2904, 16'h2710, 16'h251C,
    16'h2328, 16'h2135, 16'h1D4C, 16'h1B58, 16'h1A0B, 16'h1770, 16'h157B, 16'h0D05};
  localparam logic [3:0] SPCC_CODE_ALT = 4'h8;
  localparam logic [15:0] SPCC_FREQ_ALT_REG = 16'h238C;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    spcc_st_idle = 3'b000,
    spcc_st_rx = 3'b001,
    spcc_st_rack = 3'b011,
    spcc_st_tx = 3'b010,
    spcc_st_tack = 3'b110
  } spcc_state_type;

  typedef struct packed {
    logic [7:0] func;
    logic [7:0] gate;
    logic [3:0] code;
  } spcc_xfer_type;

endpackage

// [verilog/spcc_top.sv]
// serial slave, configuration latches and output control of the clock generator
module spcc_top
  import spcc_pkg::*;
#(
  parameter int NUM_OUTPUTS = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [3:0] freq_select_pins,
  input wire logic clk_stop_n,
  input wire logic synth_clk,
  output logic [NUM_OUTPUTS-1:0] out_run,
  output logic out_hiz,
  output logic spread_en,
  output logic spread_deep,
  output logic [3:0] freq_code,
  output logic [15:0] freq_10khz
);

  // ==========================================================
  // elaboration checks
  generate
    if (NUM_OUTPUTS != 8) begin : g_bad_outputs
      $error("output gating byte serves exactly eight outputs");
    end
    if (SPCC_SCL_HIGH_CYCLES < SPCC_MIN_SAMPLE_CYCLES) begin : g_bad_clock
      $error("core clock too slow to sample the serial bus");
    end
  endgenerate

  // ==========================================================
  // pin synchronisers, core domain
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic [3:0] fs_m, fs_s;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fs_m <= 4'h0;
      fs_s <= 4'h0;
    end else begin
      fs_m <= freq_select_pins;
      fs_s <= fs_m;
    end
  end

  // ==========================================================
  // bus events
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // sampling well above the bus rate keeps these clean up to 100 kbit/s; see [R12]
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================
  // serial engine
  spcc_state_type state;
  logic [6:0] rx_sh;
  logic [7:0] tx_sh;
  logic [2:0] bit_cnt;
  logic [3:0] pos;
  logic byte_end;
  logic ack_ok;
  logic is_read;
  logic drive_low;
  logic [7:0] cfg;
  logic [7:0] gate;
  logic [7:0] rx_byte;
  logic wr_data;
  logic [3:0] data_idx;
  logic [7:0] next_tx;

  assign rx_byte = {rx_sh, sda_s};
  assign wr_data = ~is_read && (pos >= SPCC_POS_WR_DATA);
  assign data_idx = pos - SPCC_POS_WR_DATA;

  function automatic logic [7:0] read_byte(input logic [3:0] p, input logic [7:0] c, input logic [7:0] g);
    logic [7:0] b;
    b = 8'h00;
    if (p == SPCC_POS_RD_DATA - 4'h1) begin
      b = SPCC_BYTE_COUNT; // see [R9]
    end else if (p == SPCC_POS_RD_DATA + SPCC_REG_CFG) begin
      b = c; // see [R11]
    end else if (p == SPCC_POS_RD_DATA + SPCC_REG_GATE) begin
      b = g; // see [R11]
    end
    return b;
  endfunction

  // byte that the next transmit phase loads
  assign next_tx = read_byte(pos + 4'h1, cfg, gate);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= spcc_st_idle;
      rx_sh <= 7'h00;
      tx_sh <= 8'h00;
      bit_cnt <= 3'h0;
      pos <= 4'h0;
      byte_end <= 1'b0;
      ack_ok <= 1'b0;
      is_read <= 1'b0;
      drive_low <= 1'b0;
    end else if (bus_start) begin
      // repeated start drops any half byte; see [R7]
      state <= spcc_st_rx;
      bit_cnt <= 3'h0;
      pos <= 4'h0;
      byte_end <= 1'b0;
      is_read <= 1'b0;
      drive_low <= 1'b0;
    end else if (bus_stop) begin
      state <= spcc_st_idle;
      byte_end <= 1'b0;
      drive_low <= 1'b0;
    end else begin
      case (state)
        spcc_st_rx: begin
          if (scl_rise) begin
            rx_sh <= rx_byte[6:0];
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == SPCC_LAST_BIT) begin
              // only a whole byte counts; see [R13]
              byte_end <= 1'b1;
              if (pos == 4'h0) begin
                // see [R1] [R8]
                ack_ok <= (rx_byte == SPCC_WR_ADDR) || (rx_byte == SPCC_RD_ADDR);
                is_read <= rx_byte == SPCC_RD_ADDR;
              end else begin
                // command and count are acked, bytes past 5 are refused; see [R2] [R4] [R5]
                ack_ok <= ~wr_data || (data_idx <= SPCC_LAST_DATA);
              end
            end
          end else if (scl_fall && byte_end) begin
            byte_end <= 1'b0;
            if (ack_ok) begin
              drive_low <= 1'b1; // see [R4]
              state <= spcc_st_rack;
            end else begin
              state <= spcc_st_idle;
            end
          end
        end
        spcc_st_rack: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            pos <= pos + 4'h1;
            if (is_read) begin
              // count byte first, then data in order; see [R9]
              tx_sh <= next_tx;
              drive_low <= ~next_tx[7];
              state <= spcc_st_tx;
            end else begin
              drive_low <= 1'b0;
              state <= spcc_st_rx;
            end
          end
        end
        spcc_st_tx: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            byte_end <= bit_cnt == SPCC_LAST_BIT; // see [R13]
          end else if (scl_fall) begin
            if (byte_end) begin
              byte_end <= 1'b0;
              drive_low <= 1'b0;
              state <= spcc_st_tack;
            end else begin
              tx_sh <= {tx_sh[6:0], 1'b0};
              drive_low <= ~tx_sh[6];
            end
          end
        end
        spcc_st_tack: begin
          if (scl_rise) begin
            // host ack continues the block; nack or end of block ends it; see [R10]
            ack_ok <= ~sda_s && (pos < SPCC_POS_RD_DATA + SPCC_LAST_DATA);
          end else if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (ack_ok) begin
              pos <= pos + 4'h1;
              tx_sh <= next_tx;
              drive_low <= ~next_tx[7];
              state <= spcc_st_tx;
            end else begin
              state <= spcc_st_idle;
            end
          end
        end
        spcc_st_idle: begin
          drive_low <= 1'b0;
        end
        default: begin
          state <= spcc_st_idle;
          drive_low <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = drive_low;

  // ==========================================================
  // configuration latches
  logic take_byte;

  // the command byte is never decoded: data always starts at byte 0; see [R3]
  assign take_byte = (state == spcc_st_rx) && scl_rise && (bit_cnt == SPCC_LAST_BIT) && wr_data;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg <= SPCC_CFG_RESET; // see [R14] [R21]
      gate <= SPCC_GATE_RESET; // see [R14] [R22]
    end else if (take_byte && !bus_start && !bus_stop) begin
      // each whole byte lands at once; loading goes on until stop; see [R5] [R6]
      if (data_idx == SPCC_REG_CFG) begin
        cfg <= rx_byte;
      end
      if (data_idx == SPCC_REG_GATE) begin
        gate <= rx_byte;
      end
    end
  end

  // ==========================================================
  // frequency source select
  logic [3:0] eff_code;

  // see [R15] [R17]
  assign eff_code = cfg[SPCC_BIT_FSRC] ?
    {cfg[SPCC_BIT_FMSB], cfg[SPCC_BIT_FLO+2:SPCC_BIT_FLO]} : fs_s;

  // ==========================================================
  // handshake into the synthesizer domain
  spcc_xfer_type hold;
  spcc_xfer_type live;
  logic req_tgl;
  logic ack_m, ack_s;
  logic ack_tgl;

  assign live = '{func: cfg, gate: gate, code: eff_code};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_m <= 1'b0;
      ack_s <= 1'b0;
    end else begin
      ack_m <= ack_tgl;
      ack_s <= ack_m;
    end
  end

  // hold stays put until the far side has taken it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold <= '{func: SPCC_CFG_RESET, gate: SPCC_GATE_RESET, code: 4'h0};
      req_tgl <= 1'b0;
    end else if ((ack_s == req_tgl) && (hold != live)) begin
      hold <= live;
      req_tgl <= ~req_tgl;
    end
  end

  // ==========================================================
  // synthesizer domain
  logic srst_m, srst;
  logic req_m, req_s, req_d;
  logic stop_m, stop_s;
  spcc_xfer_type cur;

  always_ff @(posedge synth_clk) begin
    srst_m <= rst;
    srst <= srst_m;
  end

  always_ff @(posedge synth_clk) begin
    if (srst) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
      req_d <= 1'b0;
      stop_m <= 1'b1;
      stop_s <= 1'b1;
    end else begin
      req_m <= req_tgl;
      req_s <= req_m;
      req_d <= req_s;
      stop_m <= clk_stop_n;
      stop_s <= stop_m;
    end
  end

  // reset value matches the core side defaults so nothing glitches
  always_ff @(posedge synth_clk) begin
    if (srst) begin
      cur <= '{func: SPCC_CFG_RESET, gate: SPCC_GATE_RESET, code: 4'h0};
      ack_tgl <= 1'b0;
    end else if (req_s != req_d) begin
      cur <= hold;
      ack_tgl <= req_s;
    end
  end

  // ==========================================================
  // output control
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_out
      always_ff @(posedge synth_clk) begin
        if (srst) begin
          out_run[gi] <= SPCC_GATE_RESET[gi];
        end else begin
          // stop-all overrides the per-output bit; see [R22] [R23]
          out_run[gi] <= cur.gate[gi] & stop_s;
        end
      end
    end
  endgenerate

  always_ff @(posedge synth_clk) begin
    if (srst) begin
      out_hiz <= 1'b0;
      spread_en <= 1'b0;
      spread_deep <= 1'b0;
    end else begin
      out_hiz <= cur.func[SPCC_BIT_HIZ]; // see [R20]
      spread_en <= cur.func[SPCC_BIT_SPREAD]; // see [R18]
      spread_deep <= cur.func[SPCC_BIT_DEPTH]; // see [R19]
    end
  end

  // the two tables differ only at code 1000
  always_ff @(posedge synth_clk) begin
    if (srst) begin
      freq_code <= 4'h0;
      freq_10khz <= SPCC_FREQ_TABLE[0];
    end else begin
      freq_code <= cur.code;
      if (cur.func[SPCC_BIT_FSRC] && (cur.code == SPCC_CODE_ALT)) begin
        freq_10khz <= SPCC_FREQ_ALT_REG; // see [R17]
      end else begin
        freq_10khz <= SPCC_FREQ_TABLE[cur.code]; // see [R16]
      end
    end
  end

endmodule
